// ---- src/ssp_dev.sv ----
// sensor serial port: bus slave with auto-incrementing register pointer
// Summary of operation
// - slave only; scl input, sda open-drain
// - works for scl from zero to 400 kHz
// - master starts transfers and makes scl
// - data changes only while scl low
// - start is sda fall, stop sda rise, scl high
// - bytes of eight bits msb first, ninth acknowledges
// - receiver holds sda low through ninth pulse
// - master may stop after a missing acknowledge
// - master naks last read byte; device releases
// - repeated start acts like a fresh start
// - first byte: seven address bits, then direction
// - answer only slave address 15h
// - first written byte loads register pointer
// - later written bytes stored only in the bus-writable slot 4, pointer advances
// - read: write pointer, repeated start, read
// - reads return pointed register, pointer advances
// - master waits 20 ms after power-up
// - both lines never low over 10 ms; a stalled read can leave both low with no limit
`timescale 1ns/1ps
module ssp_dev (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_link_clock,
    ssp_if.device bus,
    input wire logic i_load_valid,
    output logic o_load_ready,
    input wire logic [7:0] i_load_addr,
    input wire logic [7:0] i_load_data,
    output logic o_wr_valid,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data
);
    // address lies inside the implemented bank
    function automatic logic in_map(input logic [7:0] addr);
        in_map = addr < ssp_pkg::REG_LIMIT;
    endfunction : in_map

    function automatic logic [ssp_pkg::REG_INDEX_BITS-1:0] slot(
        input logic [7:0] addr);
        slot = addr[ssp_pkg::REG_INDEX_BITS-1:0];
    endfunction : slot

    // ---- link domain signals
    logic link_rst_meta;
    logic link_rst;
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    ssp_pkg::ssp_dev_state_type state;
    ssp_pkg::ssp_phase_type phase;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic rw;
    logic acked;
    logic drive_low;
    logic [7:0] regs [ssp_pkg::REG_COUNT];
    logic wr_toggle;
    logic [7:0] wr_addr_hold;
    logic [7:0] wr_data_hold;
    logic load_meta;
    logic load_sync;
    logic load_seen;

    // ---- user domain signals
    logic load_req;
    logic [7:0] load_addr_hold;
    logic [7:0] load_data_hold;
    logic ack_meta;
    logic ack_sync;
    logic wr_meta;
    logic wr_sync;
    logic wr_prev;
    logic wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;

    // bus conditions seen on synchronised lines
    wire scl_rise = scl_sync && !scl_prev;
    wire scl_fall = !scl_sync && scl_prev;
    wire start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
    wire stop_seen = scl_sync && scl_prev && !sda_prev && sda_sync;
    wire byte_done = state == ssp_pkg::DS_RECV && scl_fall
        && cnt == ssp_pkg::ACK_BIT;
    wire addr_match = shift[7:1] == ssp_pkg::SLAVE_ADDR;
    wire writable = in_map(ptr) && ssp_pkg::WRITABLE_MASK[slot(ptr)];
    wire store_now = byte_done && phase == ssp_pkg::PH_DATA && writable;
    wire [7:0] rd_value = in_map(ptr) ? regs[slot(ptr)]
        : ssp_pkg::READ_ZERO;
    wire load_now = load_sync != load_seen;

    // open drain: only ever pull low, scl is never driven
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = drive_low;
    assign o_load_ready = load_req == ack_sync;
    assign o_wr_valid = wr_valid;
    assign o_wr_addr = wr_addr;
    assign o_wr_data = wr_data;

    // reset and bus pins enter the link domain through two flops
    always_ff @(posedge i_link_clock) begin
        link_rst_meta <= i_rst;
        link_rst <= link_rst_meta;
        scl_meta <= bus.scl;
        scl_sync <= scl_meta;
        scl_prev <= scl_sync;
        sda_meta <= bus.sda;
        sda_sync <= sda_meta;
        sda_prev <= sda_sync;
        load_meta <= load_req;
        load_sync <= load_meta;
    end

    // protocol engine; scl may stop at any point, so nothing here times out
    always_ff @(posedge i_link_clock) begin
        if (link_rst) begin
            state <= ssp_pkg::DS_IDLE;
            phase <= ssp_pkg::PH_ADDR;
            shift <= 8'h00;
            cnt <= ssp_pkg::BIT_ZERO;
            ptr <= 8'h00;
            rw <= 1'b0;
            acked <= 1'b0;
            drive_low <= 1'b0;
        end else if (start_seen) begin
            // same path for first and repeated start
            state <= ssp_pkg::DS_RECV;
            phase <= ssp_pkg::PH_ADDR;
            cnt <= ssp_pkg::BIT_ZERO;
            drive_low <= 1'b0;
        end else if (stop_seen) begin
            state <= ssp_pkg::DS_IDLE;
            drive_low <= 1'b0;
        end else begin
            unique case (state)
                ssp_pkg::DS_IDLE: begin
                    drive_low <= 1'b0;
                end
                ssp_pkg::DS_RECV: begin
                    if (scl_rise && cnt != ssp_pkg::ACK_BIT) begin
                        shift <= {shift[6:0], sda_sync};
                        cnt <= cnt + 4'h1;
                    end else if (byte_done) begin
                        unique case (phase)
                            ssp_pkg::PH_ADDR: begin
                                if (addr_match) begin
                                    rw <= shift[0];
                                    phase <= ssp_pkg::PH_PTR;
                                    drive_low <= 1'b1;
                                    state <= ssp_pkg::DS_ACK;
                                end else begin
                                    state <= ssp_pkg::DS_IDLE;
                                end
                            end
                            ssp_pkg::PH_PTR: begin
                                ptr <= shift;
                                phase <= ssp_pkg::PH_DATA;
                                drive_low <= 1'b1;
                                state <= ssp_pkg::DS_ACK;
                            end
                            ssp_pkg::PH_DATA: begin
                                // acked even when dropped
                                ptr <= ptr + 8'h01;
                                drive_low <= 1'b1;
                                state <= ssp_pkg::DS_ACK;
                            end
                        endcase
                    end
                end
                ssp_pkg::DS_ACK: begin
                    // hold low until the ninth pulse falls
                    if (scl_fall) begin
                        cnt <= ssp_pkg::BIT_ZERO;
                        if (rw) begin
                            shift <= rd_value;
                            ptr <= ptr + 8'h01;
                            drive_low <= !rd_value[7];
                            state <= ssp_pkg::DS_SEND;
                        end else begin
                            drive_low <= 1'b0;
                            state <= ssp_pkg::DS_RECV;
                        end
                    end
                end
                ssp_pkg::DS_SEND: begin
                    if (scl_fall) begin
                        if (cnt == ssp_pkg::LAST_BIT) begin
                            drive_low <= 1'b0;
                            state <= ssp_pkg::DS_MACK;
                        end else begin
                            shift <= {shift[6:0], 1'b0};
                            drive_low <= !shift[6];
                            cnt <= cnt + 4'h1;
                        end
                    end
                end
                ssp_pkg::DS_MACK: begin
                    if (scl_rise) begin
                        acked <= !sda_sync;
                    end else if (scl_fall) begin
                        cnt <= ssp_pkg::BIT_ZERO;
                        if (acked) begin
                            shift <= rd_value;
                            ptr <= ptr + 8'h01;
                            drive_low <= !rd_value[7];
                            state <= ssp_pkg::DS_SEND;
                        end else begin
                            // nak ends the read with the line released
                            drive_low <= 1'b0;
                            state <= ssp_pkg::DS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // register bank; a user load wins over a bus store on the same slot
    always_ff @(posedge i_link_clock) begin
        if (link_rst) begin
            for (int i = 0; i < ssp_pkg::REG_COUNT; i++) begin
                regs[i] <= ssp_pkg::REG_RESET;
            end
        end else begin
            if (store_now) begin
                regs[slot(ptr)] <= shift;
            end
            if (load_now && in_map(load_addr_hold)) begin
                regs[slot(load_addr_hold)] <= load_data_hold;
            end
        end
    end

    // bus store notice and load acknowledge, sent as toggles
    always_ff @(posedge i_link_clock) begin
        if (link_rst) begin
            wr_toggle <= 1'b0;
            wr_addr_hold <= 8'h00;
            wr_data_hold <= 8'h00;
            load_seen <= 1'b0;
        end else begin
            load_seen <= load_sync;
            if (store_now) begin
                wr_toggle <= !wr_toggle;
                wr_addr_hold <= ptr;
                wr_data_hold <= shift;
            end
        end
    end

    // user domain: held load words stay still until the toggle returns
    always_ff @(posedge i_clock) begin
        ack_meta <= load_seen;
        ack_sync <= ack_meta;
        wr_meta <= wr_toggle;
        wr_sync <= wr_meta;
        if (i_rst) begin
            load_req <= 1'b0;
            load_addr_hold <= 8'h00;
            load_data_hold <= 8'h00;
            wr_prev <= 1'b0;
            wr_valid <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_prev <= wr_sync;
            wr_valid <= wr_sync != wr_prev;
            if (wr_sync != wr_prev) begin
                // bytes are microseconds apart, so the hold is settled
                wr_addr <= wr_addr_hold;
                wr_data <= wr_data_hold;
            end
            if (i_load_valid && o_load_ready) begin
                load_req <= !load_req;
                load_addr_hold <= i_load_addr;
                load_data_hold <= i_load_data;
            end
        end
    end
endmodule : ssp_dev

// ---- src/ssp_host.sv ----
// bus master end: byte-level command port driving the two-wire bus
`timescale 1ns/1ps
module ssp_host #(
    parameter int POWERUP_CYCLES = ssp_pkg::POWERUP_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst,
    ssp_if.host bus,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic i_cmd_start,
    input wire logic i_cmd_stop,
    input wire logic i_cmd_read,
    input wire logic i_cmd_last,
    input wire logic [7:0] i_cmd_data,
    output logic o_rsp_valid,
    output logic [7:0] o_rsp_data,
    output logic o_rsp_nak
);
    localparam int WAIT_W = $clog2(POWERUP_CYCLES + 1);
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(POWERUP_CYCLES);

    ssp_pkg::ssp_host_state_type state;
    logic [WAIT_W-1:0] wait_cnt;
    logic [5:0] div;
    logic [1:0] quarter;
    logic [3:0] bit_idx;
    logic [7:0] tx;
    logic [7:0] rx;
    logic do_stop;
    logic do_read;
    logic do_last;
    logic scl_low;
    logic sda_low;
    logic sda_meta;
    logic sda_sync;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nak;

    // quarter tick; scl runs only while a byte is in flight
    wire busy = state == ssp_pkg::HS_START || state == ssp_pkg::HS_BIT
        || state == ssp_pkg::HS_STOP;
    wire tick = busy && div == ssp_pkg::QUARTER_LAST;
    wire data_bit = bit_idx != ssp_pkg::ACK_BIT;
    wire next_sda_bit = data_bit ? (!do_read && !tx[7])
        : (do_read && !do_last);

    assign o_cmd_ready = state == ssp_pkg::HS_IDLE;
    assign o_rsp_valid = rsp_valid;
    assign o_rsp_data = rsp_data;
    assign o_rsp_nak = rsp_nak;
    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe = scl_low;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = sda_low;

    // data line is a pin: two flops before use
    always_ff @(posedge i_clock) begin
        sda_meta <= bus.sda;
        sda_sync <= sda_meta;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || !busy) begin
            div <= ssp_pkg::QUARTER_ZERO;
        end else begin
            div <= tick ? ssp_pkg::QUARTER_ZERO : div + 6'h01;
        end
    end

    // byte engine; each quarter does its edge at the tick that ends it
    always_ff @(posedge i_clock) begin
        rsp_valid <= 1'b0;
        if (i_rst) begin
            state <= ssp_pkg::HS_WAIT;
            wait_cnt <= '0;
            quarter <= ssp_pkg::Q_SETUP;
            bit_idx <= ssp_pkg::BIT_ZERO;
            tx <= 8'h00;
            rx <= 8'h00;
            do_stop <= 1'b0;
            do_read <= 1'b0;
            do_last <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nak <= 1'b0;
        end else begin
            unique case (state)
                ssp_pkg::HS_WAIT: begin
                    // quiet after power-up before any traffic
                    wait_cnt <= wait_cnt + 1'b1;
                    if (wait_cnt == WAIT_LAST) begin
                        state <= ssp_pkg::HS_IDLE;
                    end
                end
                ssp_pkg::HS_IDLE: begin
                    if (i_cmd_valid) begin
                        tx <= i_cmd_data;
                        do_stop <= i_cmd_stop;
                        do_read <= i_cmd_read;
                        do_last <= i_cmd_last;
                        quarter <= ssp_pkg::Q_SETUP;
                        bit_idx <= ssp_pkg::BIT_ZERO;
                        state <= i_cmd_start ? ssp_pkg::HS_START
                            : ssp_pkg::HS_BIT;
                    end
                end
                ssp_pkg::HS_START: begin
                    if (tick) begin
                        quarter <= quarter + 2'h1;
                        unique case (quarter)
                            ssp_pkg::Q_SETUP: sda_low <= 1'b0;
                            ssp_pkg::Q_HIGH: scl_low <= 1'b0;
                            ssp_pkg::Q_SAMPLE: sda_low <= 1'b1;
                            ssp_pkg::Q_FALL: begin
                                scl_low <= 1'b1;
                                state <= ssp_pkg::HS_BIT;
                            end
                        endcase
                    end
                end
                ssp_pkg::HS_BIT: begin
                    if (tick) begin
                        quarter <= quarter + 2'h1;
                        unique case (quarter)
                            ssp_pkg::Q_SETUP: sda_low <= next_sda_bit;
                            ssp_pkg::Q_HIGH: scl_low <= 1'b0;
                            ssp_pkg::Q_SAMPLE: begin
                                if (data_bit) begin
                                    rx <= {rx[6:0], sda_sync};
                                end else begin
                                    rsp_nak <= sda_sync;
                                end
                            end
                            ssp_pkg::Q_FALL: begin
                                scl_low <= 1'b1;
                                tx <= {tx[6:0], 1'b0};
                                bit_idx <= bit_idx + 4'h1;
                                if (!data_bit) begin
                                    state <= do_stop ? ssp_pkg::HS_STOP
                                        : ssp_pkg::HS_DONE;
                                end
                            end
                        endcase
                    end
                end
                ssp_pkg::HS_STOP: begin
                    if (tick) begin
                        quarter <= quarter + 2'h1;
                        unique case (quarter)
                            ssp_pkg::Q_SETUP: sda_low <= 1'b1;
                            ssp_pkg::Q_HIGH: scl_low <= 1'b0;
                            ssp_pkg::Q_SAMPLE: sda_low <= 1'b0;
                            ssp_pkg::Q_FALL: state <= ssp_pkg::HS_DONE;
                        endcase
                    end
                end
                ssp_pkg::HS_DONE: begin
                    // free data a cycle after scl fell, so a stalled user leaves both lines
                    // low only while the device drives a zero read bit
                    sda_low <= 1'b0;
                    rsp_data <= rx;
                    rsp_valid <= 1'b1;
                    state <= ssp_pkg::HS_IDLE;
                end
            endcase
        end
    end
endmodule : ssp_host

// ---- src/ssp_if.sv ----
// two-wire bus carrier joining the sensor port and its master
`timescale 1ns/1ps
interface ssp_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups: a line is low only while someone drives low
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport device (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport host (
        input scl,
        input sda,
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe
    );
endinterface : ssp_if

// ---- src/ssp_pkg.sv ----
// shared constants and types for the sensor serial port ends
package ssp_pkg;
    // bus addressing
    localparam logic [6:0] SLAVE_ADDR = 7'h15;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    // register bank: eight slots, only slot 4 is writable from the bus
    localparam int REG_COUNT = 8;
    localparam int REG_INDEX_BITS = 3;
    localparam logic [7:0] REG_LIMIT = 8'h08;
    localparam logic [7:0] WRITABLE_MASK = 8'h10;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // timing
    localparam int CLOCK_KHZ = 50000;
    localparam int SCL_MAX_KHZ = 400;
    localparam int QUARTER_CYCLES =
        (CLOCK_KHZ + 4 * SCL_MAX_KHZ - 1) / (4 * SCL_MAX_KHZ);
    localparam logic [5:0] QUARTER_LAST = 6'(QUARTER_CYCLES - 1);
    localparam logic [5:0] QUARTER_ZERO = 6'h00;
    localparam int POWERUP_MS = 20;
    localparam int POWERUP_CYCLES = POWERUP_MS * CLOCK_KHZ;
    // quarters of one bit period on the master side
    localparam logic [1:0] Q_SETUP = 2'h0;
    localparam logic [1:0] Q_HIGH = 2'h1;
    localparam logic [1:0] Q_SAMPLE = 2'h2;
    localparam logic [1:0] Q_FALL = 2'h3;

    typedef enum logic [4:0] {
        DS_IDLE = 5'b00001,
        DS_RECV = 5'b00010,
        DS_ACK = 5'b00100,
        DS_SEND = 5'b01000,
        DS_MACK = 5'b10000
    } ssp_dev_state_type;

    typedef enum logic [2:0] {
        PH_ADDR = 3'b001,
        PH_PTR = 3'b010,
        PH_DATA = 3'b100
    } ssp_phase_type;

    typedef enum logic [5:0] {
        HS_WAIT = 6'b000001,
        HS_IDLE = 6'b000010,
        HS_START = 6'b000100,
        HS_BIT = 6'b001000,
        HS_STOP = 6'b010000,
        HS_DONE = 6'b100000
    } ssp_host_state_type;
endpackage : ssp_pkg

// ---- testbench/ssp_chk.sv ----
// wire-level checks on the link between the master end and the sensor port
`timescale 1ns/1ps
module ssp_chk (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe
);
    logic scl_q, sda_q, first, rd, sel, seen;
    logic [3:0] bitn;
    logic [7:0] shreg, per;
    wire rise = scl && !scl_q;
    wire start = scl && scl_q && sda_q && !sda;
    wire stop = scl && scl_q && !sda_q && sda;
    wire match = shreg[7:1] == ssp_pkg::SLAVE_ADDR;
    wire nine = rise && bitn == 4'h8;
    // previous levels and cycles since the last clock rise (saturates)
    always_ff @(posedge i_clock) begin
        scl_q <= i_rst | scl;
        sda_q <= i_rst | sda;
        per <= (rise || i_rst) ? 8'h00 : per + {7'h00, per != 8'hff};
        seen <= !i_rst && (seen || rise);
    end
    // bit position, address phase and direction, rebuilt at every start
    always_ff @(posedge i_clock) begin
        if (i_rst || start) begin
            bitn <= 4'h0;
            shreg <= 8'h00;
            {first, rd, sel} <= 3'b100;
        end else if (rise) begin
            bitn <= nine ? 4'h0 : bitn + 4'h1;
            shreg <= nine ? shreg : {shreg[6:0], sda};
            first <= first && !nine;
            sel <= (first && nine) ? match : sel;
            rd <= (first && nine) ? shreg[0] && match : rd;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // pull low only while addressed, or while acking its own address
    property p_open_drain;
        dev_sda_oe |-> !dev_sda_o && (sel || (first && bitn == 4'h8));
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("device drove data line high");
    property p_idle; $fell(i_rst) |-> scl && sda; endproperty
    a_idle: assert property (p_idle)
        else $error("bus not idle after reset");
    property p_oe_change; $changed(dev_sda_oe) |-> !scl; endproperty
    a_oe_change: assert property (p_oe_change)
        else $error("device moved data line while clock high");
    property p_ack_addr; nine && first |-> dev_sda_oe == match; endproperty
    a_ack_addr: assert property (p_ack_addr)
        else $error("address acknowledge wrong");
    property p_ack_data; nine && !first && sel && !rd |-> dev_sda_oe;
    endproperty
    a_ack_data: assert property (p_ack_data)
        else $error("written byte not acknowledged");
    property p_rd_release; nine && !first && rd |-> !dev_sda_oe; endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("device held data line in read acknowledge");
    // the stop's own clock rise is counted as one
    property p_frame; stop |-> bitn == 4'h1; endproperty
    a_frame: assert property (p_frame)
        else $error("stop inside a byte");
    property p_period; rise && seen |-> per >= 8'h7c; endproperty
    a_period: assert property (p_period)
        else $error("serial clock above 400 kHz");
endmodule : ssp_chk

// ---- testbench/ssp_tb.sv ----
// self-checking bench: master end and sensor port joined over the bus
`timescale 1ns/1ps
module ssp_tb;
    localparam int D = 2;
    logic i_clock = 1'b0, i_rst = 1'b1, i_link_clock = 1'b0;
    logic i_cmd_valid = 1'b0, i_cmd_start = 1'b0, i_cmd_stop = 1'b0;
    logic i_cmd_read = 1'b0, i_cmd_last = 1'b0, i_load_valid = 1'b0;
    logic [7:0] i_cmd_data = 8'h00, i_load_addr = 8'h00, i_load_data = 8'h00;
    logic o_cmd_ready, o_rsp_valid, o_rsp_nak, o_load_ready, o_wr_valid;
    logic [7:0] o_rsp_data, o_wr_addr, o_wr_data, d;
    logic [7:0] slot [0:7];
    logic [9:0] n;
    logic [9:0] rsp_q [$]; // read flag, nak, byte
    logic [15:0] wr_q [$]; // slot, byte
    int num_errors = 0, checks_done = 0, i, seed = 32'h0d4c78cd;
    ssp_if bus ();
    ssp_host #(.POWERUP_CYCLES(20)) u_ssp_host (.i_clock, .i_rst, .bus(bus),
        .i_cmd_valid, .o_cmd_ready, .i_cmd_start, .i_cmd_stop, .i_cmd_read,
        .i_cmd_last, .i_cmd_data, .o_rsp_valid, .o_rsp_data, .o_rsp_nak);
    ssp_dev u_ssp_dev (.i_clock, .i_rst, .i_link_clock, .bus(bus),
        .i_load_valid, .o_load_ready, .i_load_addr, .i_load_data,
        .o_wr_valid, .o_wr_addr, .o_wr_data);
    ssp_chk u_ssp_chk (.i_clock, .i_rst, .scl(bus.scl), .sda(bus.sda),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe));
    // link clock offset so its phase has no tie to the user clock
    initial forever #10 i_clock = !i_clock;
    initial begin
        #1.7;
        forever #3 i_link_clock = !i_link_clock;
    end
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks_done++;
        if (exp !== got) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test;
        check("notes left", 16'h0000,
              16'(rsp_q.size() + wr_q.size()));
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // bounded wait for a handshake seen high at a rising edge
    task automatic wait_hi(ref logic s);
        int w = 0;
        do @(posedge i_clock); while (s !== 1'b1 && ++w < 5000);
        if (w >= 5000) num_errors++;
    endtask : wait_hi
    // f holds start, stop, read, last; e holds nak and the byte read
    task automatic cmd(input logic [3:0] f, input logic [7:0] dat,
                       input logic [8:0] e);
        @(posedge i_clock);
        #D {i_cmd_start, i_cmd_stop, i_cmd_read, i_cmd_last} = f;
        i_cmd_data = dat;
        i_cmd_valid = 1'b1;
        wait_hi(o_cmd_ready);
        rsp_q.push_back({f[1], e});
        #D i_cmd_valid = 1'b0;
    endtask : cmd
    task automatic load(input logic [7:0] a, input logic [7:0] dat);
        @(posedge i_clock);
        #D {i_load_addr, i_load_data, i_load_valid} = {a, dat, 1'b1};
        wait_hi(o_load_ready);
        #D i_load_valid = 1'b0;
        if (a < 8'h08) slot[a[2:0]] = dat;
    endtask : load
    // every answer or store notice takes the oldest note
    always @(posedge i_clock) begin
        if (o_rsp_valid === 1'b1) begin
            n = rsp_q.size() ? rsp_q.pop_front() : 'x;
            check("answer", 16'(n[8:0]),
                  16'({o_rsp_nak, n[9] ? o_rsp_data : n[7:0]}));
        end
        if (o_wr_valid === 1'b1)
            check("store", wr_q.size() ? wr_q.pop_front() : 'x,
                  {o_wr_addr, o_wr_data});
    end
    initial begin
        #2_000_000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        #D i_rst = 1'b0;
        for (i = 0; i < 9; i++) load(8'(i), 8'($random(seed)));
        d = 8'($random(seed));
        wr_q.push_back({8'h04, d});
        cmd(4'b1000, 8'h2a, 9'h000);
        cmd(4'b0000, 8'h04, 9'h000);
        cmd(4'b0000, d, 9'h000);
        cmd(4'b0100, ~d, 9'h000);
        slot[4] = d;
        // pointer, repeated start, three reads with the last one refused
        cmd(4'b1000, 8'h2a, 9'h000);
        cmd(4'b0000, 8'h03, 9'h000);
        cmd(4'b1000, 8'h2b, 9'h000);
        for (i = 3; i < 6; i++)
            cmd({1'b0, i == 5, 1'b1, i == 5}, 8'hff, {i == 5, slot[i]});
        cmd(4'b1100, 8'h2c, 9'h100);
        cmd(4'b1000, 8'h2a, 9'h000);
        cmd(4'b0000, 8'h07, 9'h000);
        cmd(4'b1000, 8'h2b, 9'h000);
        cmd(4'b0010, 8'hff, {1'b0, slot[7]});
        cmd(4'b0111, 8'hff, 9'h100);
        wait_hi(o_rsp_valid);
        repeat (4) @(posedge i_clock);
        stop_test();
    end
endmodule : ssp_tb
